// [dv/bop_protect_checker.sv]
module bop_protect_checker #(
  parameter int unsigned ADR_W = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic [1:0]       short_level_o,
  input wire logic             cell_voltage_input_low_i,
  input wire logic             charge_fet_o,
  input wire logic             discharge_fet_o,
  input wire logic             irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================
  // pin properties
  // ========================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // bus: one wait state, one-cycle ack, clean upper read bits
  a_ack_after_req:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper_zero:
    assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == '0)
    else $error("upper read bits not zero");
  // reset holds outputs low whatever the registers held
  a_reset_all_off: assert property (disable iff (1'b0)
    rst_i |=> !charge_fet_o && !discharge_fet_o && !irq_o)
    else $error("outputs on after reset");
  // gates and levels only move on a host write, trip or failure
  a_fet_on_by_write: assert property ($rose(charge_fet_o) |->
    $past(wb_ack_o && wb_we_i && wb_adr_i == ADR_W'(8'h04)))
    else $error("charge gate on without write");
  a_trip_clears_both: assert property ($fell(charge_fet_o) |->
    !discharge_fet_o || $past(wb_ack_o && wb_we_i))
    else $error("trip left discharge gate on");
  a_level_by_write: assert property (!$stable(short_level_o) |->
    short_level_o == 2'b00 ||
    $past(wb_ack_o && wb_we_i && wb_adr_i == ADR_W'(8'h14)))
    else $error("short level moved without write");
  a_fail_forces_off:
    assert property (cell_voltage_input_low_i [*8] |->
    !charge_fet_o && !discharge_fet_o)
    else $error("gates on during supply failure");
endmodule : bop_protect_checker

bind bop_protect bop_protect_checker #(.ADR_W(ADR_W))
  bop_protect_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .short_level_o(short_level_o),
  .cell_voltage_input_low_i(cell_voltage_input_low_i),
  .charge_fet_o(charge_fet_o), .discharge_fet_o(discharge_fet_o),
  .irq_o(irq_o)
);

// [dv/bop_sense_model.sv]
module bop_sense_model (
  input  wire logic [1:0]  dis_oc_level_i,
  input  wire logic [1:0]  short_level_i,
  input  wire logic [1:0]  chg_oc_level_i,
  input  wire logic [11:0] dis_mv_i,
  input  wire logic [11:0] chg_mv_i,
  output logic             discharge_sense_o,
  output logic             short_sense_o,
  output logic             charge_sense_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================
  // sense comparators, levels in millivolts
  // ========================================================
  localparam logic [11:0] SC_MV [4] = '{12'h0c8, 12'h15e, 12'h28a, 12'h4b0};
  // ideal comparators, no hysteresis so edge cases stay sharp
  always_comb
  begin
    discharge_sense_o = dis_mv_i > 12'h064 + 12'h014 * dis_oc_level_i;
    short_sense_o     = dis_mv_i > SC_MV[short_level_i];
    charge_sense_o    = chg_mv_i > 12'h064 + 12'h014 * chg_oc_level_i;
  end
endmodule : bop_sense_model

// [dv/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================
  // signals, tables and instances
  // ========================================================
  localparam int TK = 2;
  localparam logic [11:0] SC_MV [4] = '{12'h0c8, 12'h15e, 12'h28a, 12'h4b0};
  // case table: channel, discharge cfg, charge cfg, pre-pulse
  localparam int TCH [6] = '{0, 0, 1, 1, 2, 2};
  localparam logic [7:0] TD [6] = '{8'h00, 8'h01, 8'h03, 8'h03, 8'h03, 8'h03};
  localparam logic [7:0] TC [6] = '{8'h04, 8'h00, 8'h00, 8'h0b, 8'h00, 8'h10};
  localparam int TP [6] = '{0, 0, 40, 0, 0, 0};
  localparam logic [2:0] TF [3] = '{3'b100, 3'b010, 3'b011};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  fails = 3'b000;
  logic [11:0] dis_mv = 12'h000;
  logic [11:0] chg_mv = 12'h000;
  logic        discharge_sense_in, ssense, charge_sense_in, charge_fet_o, discharge_fet_o, irq_o;
  logic [1:0]  dis_lv, sc_lv, ch_lv;
  int          failures = 0;
  int          tests_run = 0;
  int          seed = 2;

  always #2 clk_i = ~clk_i;

  bop_protect #(.TICK_CYCLES(TK), .DOC_BASE_US(64), .COC_BASE_US(32),
    .SC_SHORT_US(3), .SC_LONG_US(20)) bop_protect_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .discharge_sense_in_i(discharge_sense_in), .short_sense_in_i(ssense),
    .charge_sense_in_i(charge_sense_in), .cell_voltage_input_low_i(fails[2]),
    .backup_supply_low_i(fails[1]), .regulator_output_low_i(fails[0]),
    .dis_oc_level_o(dis_lv), .short_level_o(sc_lv), .chg_oc_level_o(ch_lv),
    .charge_fet_o(charge_fet_o), .discharge_fet_o(discharge_fet_o),
    .irq_o(irq_o));

  bop_sense_model bop_sense_model_inst (
    .dis_oc_level_i(dis_lv), .short_level_i(sc_lv), .chg_oc_level_i(ch_lv),
    .dis_mv_i(dis_mv), .chg_mv_i(chg_mv), .discharge_sense_o(discharge_sense_in),
    .short_sense_o(ssense), .charge_sense_o(charge_sense_in));

  // ========================================================
  // tasks and expectations
  // ========================================================
  task automatic finish_test;
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one classic cycle; the bound stands in for a dead slave
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'($random(seed)), d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 20)
    begin
      failures++;
      finish_test();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'hf, q);
    chk(q, 32'(e));
  endtask : rd

  // trip delay in ticks for the channel under test
  function automatic int lim(int ch, logic [7:0] d, logic [7:0] c);
    if (ch == 0)
      return c[2] ? (64 << d[1:0]) >> 6 : 64 << d[1:0];
    if (ch == 1)
      return c[3] ? (32 << c[1:0]) >> 5 : 32 << c[1:0];
    return c[4] ? 20 : 3;
  endfunction : lim

  // drive one excess, time the trip, then clear the flag
  task automatic trip(input int i);
    logic [7:0]  d;
    logic [7:0]  c;
    logic [11:0] mv;
    int          n;
    int          l;
    d = (8'($random(seed)) & 8'h6c) | TD[i];
    c = (8'($random(seed)) & 8'h60) | TC[i];
    mv = (TCH[i] == 2) ? SC_MV[d[3:2]] + 12'h001 :
      12'h065 + 12'h014 * ((TCH[i] == 0) ? d[6:5] : c[6:5]);
    l = lim(TCH[i], d, c) * TK;
    wr(8'h14, d);
    wr(8'h18, c);
    wr(8'h0c, 8'h07);
    wr(8'h04, 8'h03);
    // a short burst first must not shorten the later count
    if (TP[i] > 0)
    begin
      chg_mv <= mv;
      repeat (TP[i]) @(posedge clk_i);
      chg_mv <= 12'h000;
      repeat (6) @(posedge clk_i);
    end
    if (TCH[i] == 1)
      chg_mv <= mv;
    else
      dis_mv <= mv;
    n = 0;
    while (discharge_fet_o !== 1'b0 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000)
    begin
      failures++;
      finish_test();
    end
    chk(32'(n >= l && n <= l + 8), 32'h0000_0001);
    chk(32'(charge_fet_o), 32'h0000_0000);
    rd(8'h10, (TCH[i] == 2) ? 8'h05 : 8'(1 << TCH[i]));
    dis_mv <= 12'h000;
    chg_mv <= 12'h000;
    repeat (2) @(posedge clk_i);
    rd(8'h08, 8'(1 << TCH[i]));
    rd(8'h04, 8'h00);
    chk(32'(irq_o), 32'h0000_0001);
    wr(8'h0c, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0000_0000);
    wr(8'h08, 8'h07);
    rd(8'h08, 8'h00);
  endtask : trip

  // ========================================================
  // main sequence
  // ========================================================
  initial
  begin
    logic [7:0]  v;
    logic [31:0] q;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 1; a < 7; a++) rd(8'(4 * a), 8'h00);
    rd(8'h3c, 8'h00);
    chk(32'(discharge_fet_o), 32'h0000_0000);
    repeat (4)
    begin
      v = 8'($random(seed));
      wr(8'h14, v);
      wr(8'h18, v);
      rd(8'h14, v & 8'h6f);
      rd(8'h18, v & 8'h7f);
      chk(32'(dis_lv), 32'(v[6:5]));
      chk(32'(sc_lv), 32'(v[3:2]));
      chk(32'(ch_lv), 32'(v[6:5]));
    end
    bus(1'b1, 8'h14, 8'hff, 4'he, q);
    rd(8'h14, v & 8'h6f);
    wr(8'h04, 8'h02);
    chk(32'({discharge_fet_o, charge_fet_o}), 32'h0000_0002);
    wr(8'h04, 8'h01);
    chk(32'({discharge_fet_o, charge_fet_o}), 32'h0000_0001);
    for (int i = 0; i < 6; i++) trip(i);
    // supply failures: cell alone, backup alone, backup with regulator
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h04, 8'h03);
      wr(8'h14, 8'h6f);
      fails <= TF[k];
      repeat (8) @(posedge clk_i);
      chk(32'(discharge_fet_o), 32'(k == 1));
      rd(8'h14, (k == 1) ? 8'h6f : 8'h00);
      rd(8'h10, (k == 1) ? 8'h00 : 8'h10);
      fails <= 3'b000;
      repeat (6) @(posedge clk_i);
    end
    finish_test();
  end
endmodule : tb

// [logic/bop_map.svh]
`ifndef BOP_MAP_SVH
`define BOP_MAP_SVH
// ==========================================================
// register indices, byte address is four times the index
// ==========================================================
`define BOP_IDX_W           6
`define BOP_IDX_FET         6'h01
`define BOP_IDX_STAT        6'h02
`define BOP_IDX_MASK        6'h03
`define BOP_IDX_LIVE        6'h04
`define BOP_IDX_DIS_CFG     6'h05
`define BOP_IDX_CHG_CFG     6'h06
// ==========================================================
// reset values and writable bits
// ==========================================================
`define BOP_RST_BYTE        8'h00
`define BOP_DIS_CFG_WMASK   8'h6f
`define BOP_CHG_CFG_WMASK   8'h7f
// ==========================================================
// timing, times in their own units
// ==========================================================
`define BOP_CLK_PERIOD_NS   4
`define BOP_TICK_NS         1000
`define BOP_TICK_CYCLES     (`BOP_TICK_NS / `BOP_CLK_PERIOD_NS)
`define BOP_DOC_BASE_US     160000
`define BOP_COC_BASE_US     80000
`define BOP_SC_SHORT_US     190
`define BOP_SC_LONG_US      10000
`define BOP_DIS_DIV_SHIFT   6
`define BOP_CHG_DIV_SHIFT   5
`endif

// [logic/bop_pkg.sv]
package bop_pkg;
  // ========================================================
  // register layouts
  // ========================================================
  typedef struct packed {
    logic rsvd7;
    logic dis_oc_level_hi;
    logic dis_oc_level_lo;
    logic rsvd4;
    logic short_level_hi;
    logic short_level_lo;
    logic dis_oc_delay_hi;
    logic dis_oc_delay_lo;
  } bop_dis_cfg_t;

  typedef struct packed {
    logic rsvd7;
    logic chg_oc_level_hi;
    logic chg_oc_level_lo;
    logic short_long_delay;
    logic chg_delay_div32;
    logic dis_delay_div64;
    logic chg_oc_delay_hi;
    logic chg_oc_delay_lo;
  } bop_chg_cfg_t;

  typedef struct packed {
    logic discharge_short_flag;
    logic charge_overcurrent_flag;
    logic discharge_overcurrent_flag;
  } bop_flags_t;

  typedef struct packed {
    logic discharge_fet_ctrl;
    logic charge_fet_ctrl;
  } bop_fet_t;

  // protection channels, also the flag bit positions
  typedef enum logic [1:0] {
    BOP_CH_DOC = 2'b00,
    BOP_CH_COC = 2'b01,
    BOP_CH_DSC = 2'b10
  } bop_chan_t;
endpackage : bop_pkg

// [logic/bop_protect.sv]
`include "bop_map.svh"
// Summary of operation
// - a sense input held over its level past its delay turns both FETs off.
// - register 5 bits 6:5 pick the discharge overcurrent level 0.10V to 0.16V.
// - register 5 bits 3:2 pick the short-circuit level 0.20V to 1.20V.
// - register 6 bits 6:5 pick the charge overcurrent level 0.10V to 0.16V.
// - register 5 bits 1:0 pick the discharge delay 160ms to 1280ms.
// - register 6 bits 1:0 pick the charge delay 80ms to 640ms.
// - register 6 bit 4 picks 190us or 10ms as the short-circuit delay.
// - register 6 bit 3 divides the charge delay by 32.
// - register 6 bit 2 divides the discharge delay by 64.
// - every register is zero after power-up, so FETs are off.
// - each trip sets its own status flag.
// - a trip clears both FET control bits.
// - a low cell supply, or backup and regulator both low, resets all registers and turns the pack off.
// - the discharge FET goes off the same way for a trip or a host clear.
// - protection runs by default with no host action.
module bop_protect #(
  parameter int unsigned TICK_CYCLES = `BOP_TICK_CYCLES,
  parameter int unsigned DOC_BASE_US = `BOP_DOC_BASE_US,
  parameter int unsigned COC_BASE_US = `BOP_COC_BASE_US,
  parameter int unsigned SC_SHORT_US = `BOP_SC_SHORT_US,
  parameter int unsigned SC_LONG_US  = `BOP_SC_LONG_US,
  parameter int unsigned DLY_W       = 21,
  parameter int unsigned ADR_W       = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // analog comparator results, asynchronous
  input  wire logic             discharge_sense_in_i,
  input  wire logic             short_sense_in_i,
  input  wire logic             charge_sense_in_i,
  // supply monitors, asynchronous, high when low
  input  wire logic             cell_voltage_input_low_i,
  input  wire logic             backup_supply_low_i,
  input  wire logic             regulator_output_low_i,
  // threshold selects to the comparators
  output logic      [1:0]       dis_oc_level_o,
  output logic      [1:0]       short_level_o,
  output logic      [1:0]       chg_oc_level_o,
  // gate drive and interrupt
  output logic                  charge_fet_o,
  output logic                  discharge_fet_o,
  output logic                  irq_o
);

  // ========================================================
  // input synchronisers
  // ========================================================
  localparam int unsigned N_IN = 6;
  logic [N_IN-1:0] async_in;
  logic [N_IN-1:0] sync1;
  logic [N_IN-1:0] sync2;
  logic [N_IN-1:0] sync3;
  logic [N_IN-1:0] clean;

  assign async_in = {regulator_output_low_i,
                     backup_supply_low_i,
                     cell_voltage_input_low_i,
                     short_sense_in_i,
                     charge_sense_in_i,
                     discharge_sense_in_i};

  // three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      clean <= '0;
    end
    else
    begin
      sync1 <= async_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < N_IN; i++)
      begin
        if (sync2[i] == sync3[i])
        begin
          clean[i] <= sync3[i];
        end
      end
    end
  end

  // channel indices, also the flag bit positions
  localparam int BOP_CH_DOC_IDX = int'(bop_pkg::BOP_CH_DOC);
  localparam int BOP_CH_COC_IDX = int'(bop_pkg::BOP_CH_COC);
  localparam int BOP_CH_DSC_IDX = int'(bop_pkg::BOP_CH_DSC);

  logic [2:0] cmp;
  logic       power_fail;
  logic       clr;

  assign cmp[BOP_CH_DOC_IDX] = clean[0];
  assign cmp[BOP_CH_COC_IDX] = clean[1];
  assign cmp[BOP_CH_DSC_IDX] = clean[2];

  // cell below por, or both backup and regulator low
  assign power_fail = clean[3] | (clean[4] & clean[5]);
  // a power failure wipes the registers like a reset
  assign clr = rst_i | power_fail;

  // ========================================================
  // microsecond time base
  // ========================================================
  localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  logic [PRE_W-1:0] pre_cnt;
  logic             tick;

  // free-running, one enable pulse per microsecond
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_cnt <= '0;
    end
    else if (pre_cnt == PRE_LAST)
    begin
      pre_cnt <= '0;
    end
    else
    begin
      pre_cnt <= pre_cnt + PRE_W'(1);
    end
  end

  assign tick = (pre_cnt == PRE_LAST);

  // ========================================================
  // registers
  // ========================================================
  bop_pkg::bop_dis_cfg_t dis_cfg;
  bop_pkg::bop_chg_cfg_t chg_cfg;
  bop_pkg::bop_fet_t     fet;
  bop_pkg::bop_flags_t   status;
  bop_pkg::bop_flags_t   mask;
  logic [2:0]            trip;
  logic                  any_trip;

  logic                  acc;
  logic                  wr;
  logic [`BOP_IDX_W-1:0] idx;
  logic [7:0]            wbyte;

  assign acc   = wb_cyc_i & wb_stb_i;
  assign idx   = wb_adr_i[`BOP_IDX_W+1:2];
  // write lands on the edge where ack is seen by the master
  assign wr    = acc & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign any_trip = |trip;

  // discharge configuration, reserved bits stay zero
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      dis_cfg <= `BOP_RST_BYTE;
    end
    else if (wr && idx == `BOP_IDX_DIS_CFG)
    begin
      dis_cfg <= wbyte & `BOP_DIS_CFG_WMASK;
    end
  end

  // charge configuration
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      chg_cfg <= `BOP_RST_BYTE;
    end
    else if (wr && idx == `BOP_IDX_CHG_CFG)
    begin
      chg_cfg <= wbyte & `BOP_CHG_CFG_WMASK;
    end
  end

  // fet control: a trip beats a host write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      fet <= '0;
    end
    else if (any_trip)
    begin
      fet <= '0;
    end
    else if (wr && idx == `BOP_IDX_FET)
    begin
      fet <= wbyte[1:0];
    end
  end

  // sticky flags, write one to clear, a new trip wins
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      status <= '0;
    end
    else if (wr && idx == `BOP_IDX_STAT)
    begin
      status <= (status & ~wbyte[2:0]) | trip;
    end
    else
    begin
      status <= status | trip;
    end
  end

  // interrupt mask, one enables a flag
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      mask <= '0;
    end
    else if (wr && idx == `BOP_IDX_MASK)
    begin
      mask <= wbyte[2:0];
    end
  end

  // ========================================================
  // bus answer
  // ========================================================
  logic [7:0] rbyte;

  // unmapped indices read zero and still answer
  always_comb
  begin
    rbyte = 8'h00;
    if (idx == `BOP_IDX_FET)
    begin
      rbyte = {6'h00, fet};
    end
    else if (idx == `BOP_IDX_STAT)
    begin
      rbyte = {5'h00, status};
    end
    else if (idx == `BOP_IDX_MASK)
    begin
      rbyte = {5'h00, mask};
    end
    else if (idx == `BOP_IDX_LIVE)
    begin
      rbyte = {3'h0, power_fail, 1'b0, cmp};
    end
    else if (idx == `BOP_IDX_DIS_CFG)
    begin
      rbyte = dis_cfg;
    end
    else if (idx == `BOP_IDX_CHG_CFG)
    begin
      rbyte = chg_cfg;
    end
  end

  // one wait state, ack for a single cycle per request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= acc & ~wb_ack_o;
      wb_dat_o <= {24'h00_0000, rbyte};
    end
  end

  // ========================================================
  // delay limits in microseconds
  // ========================================================
  logic [DLY_W-1:0] lim [3];
  logic [1:0]       doc_sel;
  logic [1:0]       coc_sel;

  assign doc_sel = {dis_cfg.dis_oc_delay_hi, dis_cfg.dis_oc_delay_lo};
  assign coc_sel = {chg_cfg.chg_oc_delay_hi, chg_cfg.chg_oc_delay_lo};

  // each select step doubles the base time
  always_comb
  begin
    lim[BOP_CH_DOC_IDX] = DLY_W'(DOC_BASE_US) << doc_sel;
    if (chg_cfg.dis_delay_div64)
    begin
      lim[BOP_CH_DOC_IDX] = lim[BOP_CH_DOC_IDX]
                            >> `BOP_DIS_DIV_SHIFT;
    end
    lim[BOP_CH_COC_IDX] = DLY_W'(COC_BASE_US) << coc_sel;
    if (chg_cfg.chg_delay_div32)
    begin
      lim[BOP_CH_COC_IDX] = lim[BOP_CH_COC_IDX]
                            >> `BOP_CHG_DIV_SHIFT;
    end
    if (chg_cfg.short_long_delay)
    begin
      lim[BOP_CH_DSC_IDX] = DLY_W'(SC_LONG_US);
    end
    else
    begin
      lim[BOP_CH_DSC_IDX] = DLY_W'(SC_SHORT_US);
    end
  end

  // ========================================================
  // qualification counters, one per channel
  // ========================================================
  // always armed, no enable bit exists to turn them off
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_chan
      logic [DLY_W-1:0] cnt;
      logic             fired;

      // the tick phase is free, so a trip needs lim to lim+1 us
      always_ff @(posedge clk_i)
      begin
        if (clr || !cmp[ch])
        begin
          cnt   <= '0;
          fired <= 1'b0;
        end
        else if (tick)
        begin
          if (cnt < lim[ch])
          begin
            cnt <= cnt + DLY_W'(1);
          end
          else if (!fired)
          begin
            fired <= 1'b1;
          end
        end
      end

      // one pulse per excess; a lowered limit trips at once, no wrap
      assign trip[ch] = cmp[ch] & tick & ~fired & ~clr
                        & (cnt >= lim[ch]);
    end
  endgenerate

  // ========================================================
  // outputs
  // ========================================================
  // level codes go straight from the config flops
  assign dis_oc_level_o = {dis_cfg.dis_oc_level_hi,
                           dis_cfg.dis_oc_level_lo};
  assign short_level_o  = {dis_cfg.short_level_hi,
                           dis_cfg.short_level_lo};
  assign chg_oc_level_o = {chg_cfg.chg_oc_level_hi,
                           chg_cfg.chg_oc_level_lo};

  // host clear and trip both act only through the control bit
  assign discharge_fet_o = fet.discharge_fet_ctrl;
  assign charge_fet_o    = fet.charge_fet_ctrl;

  // level interrupt while any unmasked flag stands
  assign irq_o = |(status & mask);
endmodule : bop_protect
